// [hdl/uart_modem_pin_steering.sv]
// uart/modem pin steering: irq gating, serial pin routing, relay, speaker
// assumes all pin inputs synchronous to clk_sys; apb slave for control
//
// Behaviour
// - irq asserts while an unmasked sticky status bit (uart or modem rising edge) is set
// - legacy bit low: irq gated by read strobe
// - irq_output_enable_bit bit off: irq pin released
// - single-port: modem detect interrupt also asserts irq
// - rx pin routed by mode and tone bit
// - tx pin mark when mode 1, bit 0
// - off-hook driver is complement of bit
// - speaker audio attenuated, four levels plus off
`timescale 1ns/10ps
`default_nettype none

module uart_modem_pin_steering
   import pin_steer_pkg::*;
#(
   parameter int SPK_W = `SPK_W
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output      logic [31:0]      prdata,
   output      logic             pready,
   output      logic             pslverr,
   // mode and host strobe
   input  wire logic             singlePortSelect,
   input  wire logic             hostReadStrobe_n,
   // interrupt sources
   input  wire logic             uartIrqPending,
   input  wire logic             modemDetectIrq,
   // uart irq pin, three-state
   output      logic             uartIrqOut,
   output      logic             uartIrqOutOe,
   // receive pin, two-way
   input  wire logic             rxdPinIn,
   output      logic             rxdPinOut,
   output      logic             rxdPinOe,
   input  wire logic             modemRxData,
   output      logic             uartSerialIn,
   // transmit pin
   input  wire logic             uartSerialOut,
   output      logic             txdPinOut,
   // off-hook open drain
   output      logic             offHookDriverOut,
   output      logic             offHookDriverOe,
   // speaker
   input  wire logic [SPK_W-1:0] rxAudio,
   output      logic [SPK_W-1:0] speakerOut,
   // summary interrupt
   output      logic             irq
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      ctrl_s              ctrl;
      logic [`IRQ_W-1:0]  irqStatus;
      logic [`IRQ_W-1:0]  irqMask;
      logic [31:0]        rdata;
      logic               ready;
      logic               slverr;
      logic               irqPin;
      logic               irqPinOe;
      logic               rxOut;
      logic               rxOe;
      logic               uartIn;
      logic               txOut;
      logic               relayOut;
      logic               relayOe;
      logic               irqSum;
      logic               uartPrev;
      logic               modemPrev;
   } state_s;

   state_s st_ff;
   state_s nxt_st;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic isReg(input logic [11:0] a, input logic [11:0] ofs);
      isReg = (a == ofs);
   endfunction

   function automatic logic [31:0] ctrlWord(input ctrl_s c);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`CTRL_LEGACY_BIT]  = c.legacyIrqStyleBit;
      w[`CTRL_IRQ_OE_BIT]  = c.irqOutputEnableBit;
      w[`CTRL_TONE7_BIT]   = c.toneCtrlTopBit;
      w[`CTRL_OFFHOOK_BIT] = c.offHook;
      w[`CTRL_ATTEN_LSB +: `CTRL_ATTEN_W] = c.atten;
      ctrlWord = w;
   endfunction

   logic apbSetup;
   logic wrStb;
   logic rdStb;
   logic irqCond;
   logic [`IRQ_W-1:0] events;

   // apb phase decode, zero wait states
   assign apbSetup  = psel && !penable;
   assign wrStb     = apbSetup && pwrite;
   assign rdStb     = apbSetup && !pwrite;

   // rising edges of the sources set sticky status
   assign events[`IRQ_UART_BIT]  = uartIrqPending && !st_ff.uartPrev;
   assign events[`IRQ_MODEM_BIT] = modemDetectIrq && !st_ff.modemPrev;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.uartPrev  = uartIrqPending;
      nxt_st.modemPrev = modemDetectIrq;
      nxt_st.ready     = apbSetup;
      nxt_st.slverr    = 1'b0;

      // register write in setup, answered next cycle
      if (wrStb) begin
         if (isReg(paddr, `OFS_CTRL)) begin
            nxt_st.ctrl.legacyIrqStyleBit  = pwdata[`CTRL_LEGACY_BIT];
            nxt_st.ctrl.irqOutputEnableBit = pwdata[`CTRL_IRQ_OE_BIT];
            nxt_st.ctrl.toneCtrlTopBit     = pwdata[`CTRL_TONE7_BIT];
            nxt_st.ctrl.offHook            = pwdata[`CTRL_OFFHOOK_BIT];
            nxt_st.ctrl.atten              = pwdata[`CTRL_ATTEN_LSB +: `CTRL_ATTEN_W];
         end else if (isReg(paddr, `OFS_IRQ_STATUS)) begin
            nxt_st.irqStatus = st_ff.irqStatus & ~pwdata[`IRQ_W-1:0];
         end else if (isReg(paddr, `OFS_IRQ_MASK)) begin
            nxt_st.irqMask = pwdata[`IRQ_W-1:0];
         end else if (!isReg(paddr, `OFS_PIN_STATE)) begin
            nxt_st.slverr = 1'b1;
         end
      end

      // set wins over clear
      nxt_st.irqStatus = nxt_st.irqStatus | events;

      // register read in setup
      if (rdStb) begin
         if (isReg(paddr, `OFS_CTRL)) begin
            nxt_st.rdata = ctrlWord(st_ff.ctrl);
         end else if (isReg(paddr, `OFS_IRQ_STATUS)) begin
            nxt_st.rdata = {30'h0, st_ff.irqStatus};
         end else if (isReg(paddr, `OFS_IRQ_MASK)) begin
            nxt_st.rdata = {30'h0, st_ff.irqMask};
         end else if (isReg(paddr, `OFS_PIN_STATE)) begin
            nxt_st.rdata = {26'h0, singlePortSelect, st_ff.relayOut, st_ff.txOut,
                            st_ff.rxOe, st_ff.irqPinOe, st_ff.irqPin};
         end else begin
            nxt_st.rdata  = 32'h0000_0000;
            nxt_st.slverr = 1'b1;
         end
      end

      // uart irq pin: pending condition plus modem detect in single-port
      irqCond = uartIrqPending
                || (singlePortSelect && modemDetectIrq);
      if (st_ff.ctrl.legacyIrqStyleBit) begin
         nxt_st.irqPin = irqCond;
      end else begin
         nxt_st.irqPin = irqCond && !hostReadStrobe_n;
      end
      nxt_st.irqPinOe = st_ff.ctrl.irqOutputEnableBit;

      // receive pin routing
      unique case ({singlePortSelect, st_ff.ctrl.toneCtrlTopBit})
         2'b00: begin
            nxt_st.rxOe   = 1'b1;
            nxt_st.rxOut  = modemRxData;
            nxt_st.uartIn = 1'b1;
         end
         2'b10: begin
            nxt_st.rxOe   = 1'b0;
            nxt_st.rxOut  = 1'b0;
            nxt_st.uartIn = 1'b1;
         end
         default: begin
            nxt_st.rxOe   = 1'b0;
            nxt_st.rxOut  = 1'b0;
            nxt_st.uartIn = rxdPinIn;
         end
      endcase

      // transmit pin: mark when single-port and tone bit low
      if (singlePortSelect && !st_ff.ctrl.toneCtrlTopBit) begin
         nxt_st.txOut = 1'b1;
      end else begin
         nxt_st.txOut = uartSerialOut;
      end

      // off-hook open drain: sinks while complement is low
      nxt_st.relayOut = !st_ff.ctrl.offHook;
      nxt_st.relayOe  = st_ff.ctrl.offHook;

      nxt_st.irqSum = |(nxt_st.irqStatus & st_ff.irqMask);
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_ff           <= '0;
         st_ff.ctrl      <= ctrl_s'(`CTRL_RESET);
         st_ff.irqMask   <= `IRQ_MASK_RESET;
         st_ff.txOut     <= 1'b1;
         st_ff.uartIn    <= 1'b1;
         st_ff.relayOut  <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // speaker path
   // ------------------------------------------------------------
   speaker_atten #(
      .SPK_W    (SPK_W)
   ) speaker_atten_inst (
      .clk_sys  (clk_sys),
      .arst_n   (arst_n),
      .atten    (st_ff.ctrl.atten),
      .audioIn  (rxAudio),
      .audioOut (speakerOut)
   );

   // ------------------------------------------------------------
   // outputs, all from flip-flops
   // ------------------------------------------------------------
   assign prdata           = st_ff.rdata;
   assign pready           = st_ff.ready;
   assign pslverr          = st_ff.slverr;
   assign uartIrqOut       = st_ff.irqPin;
   assign uartIrqOutOe     = st_ff.irqPinOe;
   assign rxdPinOut        = st_ff.rxOut;
   assign rxdPinOe         = st_ff.rxOe;
   assign uartSerialIn     = st_ff.uartIn;
   assign txdPinOut        = st_ff.txOut;
   assign offHookDriverOut = st_ff.relayOut;
   assign offHookDriverOe  = st_ff.relayOe;
   assign irq              = st_ff.irqSum;

endmodule // uart_modem_pin_steering

`default_nettype wire

// [shared/pin_steer_consts.svh]
// pin steering constants: register offsets, field positions, reset values
// assumes inclusion by bare name from package and bench files
`ifndef PIN_STEER_CONSTS_SVH
`define PIN_STEER_CONSTS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_CTRL        12'h000
`define OFS_IRQ_STATUS  12'h004
`define OFS_IRQ_MASK    12'h008
`define OFS_PIN_STATE   12'h00c

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define CTRL_LEGACY_BIT  0
`define CTRL_IRQ_OE_BIT  1
`define CTRL_TONE7_BIT   2
`define CTRL_OFFHOOK_BIT 3
`define CTRL_ATTEN_LSB   4
`define CTRL_ATTEN_W     3
`define CTRL_RESET       32'h0000_0000

// ------------------------------------------------------------
// interrupt status/mask fields
// ------------------------------------------------------------
`define IRQ_UART_BIT     0
`define IRQ_MODEM_BIT    1
`define IRQ_W            2
`define IRQ_MASK_RESET   2'h0

// ------------------------------------------------------------
// speaker attenuation
// ------------------------------------------------------------
`define ATTEN_OFF        3'h4
`define SPK_W            8

`endif

// [shared/pin_steer_pkg.sv]
// pin steering types shared by the design files
// assumes the constants header is on the include path
`include "pin_steer_consts.svh"

package pin_steer_pkg;

   // ------------------------------------------------------------
   // control word carried to the steering logic
   // ------------------------------------------------------------
   typedef struct packed {
      logic [`CTRL_ATTEN_W-1:0] atten;
      logic                     offHook;
      logic                     toneCtrlTopBit;
      logic                     irqOutputEnableBit;
      logic                     legacyIrqStyleBit;
   } ctrl_s;

   // ------------------------------------------------------------
   // apb request bundle
   // ------------------------------------------------------------
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

endpackage : pin_steer_pkg

// [hdl/speaker_atten.sv]
// speaker attenuator: registered shift of received audio by a setting
// assumes audio samples synchronous to clk_sys, signed two's complement
`timescale 1ns/10ps
`default_nettype none

module speaker_atten
   import pin_steer_pkg::*;
#(
   parameter int SPK_W = `SPK_W
) (
   // clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     arst_n,
   // setting and audio
   input  wire logic [`CTRL_ATTEN_W-1:0] atten,
   input  wire logic [SPK_W-1:0]         audioIn,
   output      logic [SPK_W-1:0]         audioOut
);

   logic [SPK_W-1:0] audio_ff;
   logic [SPK_W-1:0] nxt_audio;

   // ------------------------------------------------------------
   // four volume levels, any code from off upward mutes
   // ------------------------------------------------------------
   always_comb begin
      if (atten >= `ATTEN_OFF) begin
         nxt_audio = '0;
      end else begin
         nxt_audio = $signed(audioIn) >>> atten;
      end
   end

   // output register
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         audio_ff <= '0;
      end else begin
         audio_ff <= nxt_audio;
      end
   end

   assign audioOut = audio_ff;

endmodule // speaker_atten

`default_nettype wire

// [tb/pin_steer_props.sv]
// checker: port-level properties of the pin steering block
// assumes bind from the bench top; control word shadowed from apb writes
`timescale 1ns/10ps
`default_nettype none

module pin_steer_props #(
   parameter int SPK_W = 8
) (
   // clock and reset
   input wire logic             clk_sys,
   input wire logic             arst_n,
   // apb
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic [11:0]      paddr,
   input wire logic [31:0]      pwdata,
   input wire logic             pready,
   // interrupt pin
   input wire logic             singlePortSelect,
   input wire logic             hostReadStrobe_n,
   input wire logic             uartIrqPending,
   input wire logic             modemDetectIrq,
   input wire logic             uartIrqOut,
   input wire logic             uartIrqOutOe,
   // serial pins
   input wire logic             rxdPinIn,
   input wire logic             rxdPinOut,
   input wire logic             rxdPinOe,
   input wire logic             modemRxData,
   input wire logic             uartSerialIn,
   input wire logic             uartSerialOut,
   input wire logic             txdPinOut,
   // relay and speaker
   input wire logic             offHookDriverOut,
   input wire logic             offHookDriverOe,
   input wire logic [SPK_W-1:0] rxAudio,
   input wire logic [SPK_W-1:0] speakerOut
);
   // ------------------------------------------------------------
   // helper logic
   // ------------------------------------------------------------
   logic [6:0] ctrlShadow_ff;
   logic       live_ff;
   logic       cause;

   // irq cause before read-strobe gating
   assign cause = uartIrqPending | (singlePortSelect & modemDetectIrq);

   // shadow control at the accepting edge; live one edge after reset
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ctrlShadow_ff <= 7'h00;
         live_ff       <= 1'h0;
      end else begin
         live_ff <= 1'h1;
         if (psel && penable && pready && pwrite && paddr == 12'h000) begin
            ctrlShadow_ff <= pwdata[6:0];
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   a_irq_pin_value: assert property (
      live_ff |-> uartIrqOut == ($past(cause) & (ctrlShadow_ff[0] | !$past(hostReadStrobe_n))))
      else $error("irq pin value wrong");
   a_irq_pin_oe: assert property (
      live_ff |-> uartIrqOutOe == ctrlShadow_ff[1]) else $error("irq pin enable wrong");
   a_rx_modem_drive: assert property (
      live_ff && !$past(singlePortSelect) && !ctrlShadow_ff[2] |-> rxdPinOe && rxdPinOut == $past(modemRxData))
      else $error("rx pin not driven by modem");
   a_rx_pin_ignored: assert property (
      live_ff && $past(singlePortSelect) && !ctrlShadow_ff[2] |-> !rxdPinOe && uartSerialIn)
      else $error("rx pin not ignored");
   a_rx_to_uart: assert property (
      live_ff && ctrlShadow_ff[2] |-> !rxdPinOe && uartSerialIn == $past(rxdPinIn))
      else $error("rx pin not fed to uart");
   a_tx_route: assert property (
      live_ff |-> txdPinOut == (($past(singlePortSelect) && !ctrlShadow_ff[2]) | $past(uartSerialOut)))
      else $error("tx pin route wrong");
   a_off_hook_drive: assert property (
      live_ff |-> offHookDriverOut == !ctrlShadow_ff[3] && offHookDriverOe == ctrlShadow_ff[3])
      else $error("off-hook drive wrong");
   a_speaker_level: assert property (
      live_ff |-> speakerOut == (ctrlShadow_ff[6] ? '0 : SPK_W'($signed($past(rxAudio)) >>> ctrlShadow_ff[5:4])))
      else $error("speaker level wrong");
   a_apb_ready_once: assert property (
      psel && !penable |=> pready ##1 !pready) else $error("apb ready not one cycle");

   // main scenarios reached
   c_legacy_gate: cover property (live_ff && !ctrlShadow_ff[0] && uartIrqOut);
   c_rx_uart: cover property (live_ff && ctrlShadow_ff[2] && !rxdPinOe);
   c_spk_mute: cover property (live_ff && ctrlShadow_ff[6]);
endmodule // pin_steer_props

`default_nettype wire

// [tb/serial_far_end.sv]
// serial equipment on the far side of the receive pin
// assumes the design splits the pin into value and enable
`timescale 1ns/10ps
`default_nettype none

module serial_far_end (
   // design side of the receive pin
   input  wire logic rxdPinOut,
   input  wire logic rxdPinOe,
   // data the equipment sends
   input  wire logic farData,
   output      logic rxdWire
);
   // wire level: equipment drives only while the device releases the pin
   assign rxdWire = rxdPinOe ? rxdPinOut : farData;
endmodule // serial_far_end

`default_nettype wire

// [tb/uart_modem_pin_steering_tb.sv]
// bench for the pin steering block: apb tasks and directed scenarios
// assumes design, checker and far-end model are compiled before it
`timescale 1ns/10ps
`default_nettype none
`include "pin_steer_consts.svh"

module uart_modem_pin_steering_tb;
   // ------------------------------------------------------------
   // bench signals
   // ------------------------------------------------------------
   logic        clk_sys = 1'h0;
   logic        arst_n = 1'h0;
   logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rdData;
   logic        pready, pslverr, rdErr, irq, rxdPinIn, rxdPinOut, rxdPinOe, uartSerialIn, txdPinOut;
   logic        singlePortSelect = 1'h0, hostReadStrobe_n = 1'h1, uartIrqPending = 1'h0, modemDetectIrq = 1'h0;
   logic        modemRxData = 1'h0, uartSerialOut = 1'h0, farData = 1'h1;
   logic        uartIrqOut, uartIrqOutOe, offHookDriverOut, offHookDriverOe;
   logic [7:0]  rxAudio = '0, speakerOut;
   int          failCount = 0, nChecks = 0, cyc = 0;

   // 100 MHz clock
   always #5 clk_sys = ~clk_sys;

   uart_modem_pin_steering #(.SPK_W(8)) uart_modem_pin_steering_inst (
      .clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .singlePortSelect, .hostReadStrobe_n, .uartIrqPending, .modemDetectIrq, .uartIrqOut, .uartIrqOutOe,
      .rxdPinIn, .rxdPinOut, .rxdPinOe, .modemRxData, .uartSerialIn, .uartSerialOut, .txdPinOut,
      .offHookDriverOut, .offHookDriverOe, .rxAudio, .speakerOut, .irq);
   serial_far_end serial_far_end_inst (.rxdPinOut, .rxdPinOe, .farData, .rxdWire(rxdPinIn));

   // ------------------------------------------------------------
   // common tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         failCount++;
         $display("MISMATCH %s exp %h seen %h", what, exp, seen);
      end
   endtask

   task automatic reportAndStop;
      $display("checks %0d mismatches %0d", nChecks, failCount);
      if (failCount == 0 && nChecks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // one apb transfer; holds the request until pready is seen
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'h1;
      // pready ends this wait; only the hang guard catches a bus that never answers
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'h1);
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic settle;
      repeat (3) @(posedge clk_sys);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic resetCase;
      check("txdRst", txdPinOut, 1);
      check("uartInRst", uartSerialIn, 1);
      check("relayRst", offHookDriverOut, 1);
      check("irqRst", uartIrqOut, 0);
      arst_n <= 1'h1;
      apb(1'h0, `OFS_CTRL, 0);
      check("ctrlRst", rdData, `CTRL_RESET);
      apb(1'h0, `OFS_IRQ_MASK, 0);
      check("maskRst", rdData, `IRQ_MASK_RESET);
   endtask

   task automatic irqPinCase;
      apb(1'h1, `OFS_CTRL, 32'h2);
      uartIrqPending <= 1'h1;
      settle();
      check("irqOe", uartIrqOutOe, 1);
      check("irqGated", uartIrqOut, 0);
      hostReadStrobe_n <= 1'h0;
      settle();
      check("irqRead", uartIrqOut, 1);
      apb(1'h1, `OFS_CTRL, 32'h3);
      hostReadStrobe_n <= 1'h1;
      settle();
      check("irqDirect", uartIrqOut, 1);
      uartIrqPending <= 1'h0;
      singlePortSelect <= 1'h1;
      modemDetectIrq <= 1'h1;
      settle();
      check("irqModem", uartIrqOut, 1);
      // legacy still set, so only the mode can drop the modem cause
      singlePortSelect <= 1'h0;
      settle();
      check("irqDual", uartIrqOut, 0);
      apb(1'h1, `OFS_CTRL, 32'h0);
      settle();
      check("irqOff", uartIrqOutOe, 0);
   endtask

   task automatic routeCase;
      logic [1:0] m;
      farData <= 1'h0;
      modemRxData <= 1'h1;
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         singlePortSelect <= m[1];
         apb(1'h1, `OFS_CTRL, {29'h0, m[0], 2'h0});
         settle();
         check("rxOe", rxdPinOe, m == 2'h0);
         if (m == 2'h0) check("rxOut", rxdPinOut, 1);
         if (m == 2'h2) check("rxIdle", uartSerialIn, 1);
         if (m[0]) check("rxUart", uartSerialIn, 0);
         check("txd", txdPinOut, m == 2'h2);
         // flip every source so a stuck route shows up
         uartSerialOut <= 1'h1;
         modemRxData <= 1'h0;
         farData <= 1'h1;
         settle();
         check("txdUart", txdPinOut, 1);
         if (m == 2'h0) check("rxOutLow", rxdPinOut, 0);
         if (m[0]) check("rxUartHigh", uartSerialIn, 1);
         uartSerialOut <= 1'h0;
         modemRxData <= 1'h1;
         farData <= 1'h0;
      end
      singlePortSelect <= 1'h0;
   endtask

   task automatic pinsCase;
      logic [7:0] e;
      for (int b = 0; b < 2; b++) begin
         apb(1'h1, `OFS_CTRL, 32'(b) << 3);
         settle();
         check("relayOut", offHookDriverOut, b == 0);
         check("relayOe", offHookDriverOe, b);
      end
      rxAudio <= 8'h90;
      for (int a = 0; a < 8; a++) begin
         e = (a >= 4) ? 8'h00 : 8'($signed(8'h90) >>> a);
         apb(1'h1, `OFS_CTRL, 32'(a) << 4);
         settle();
         check("spk", speakerOut, e);
      end
   endtask

   task automatic statusCase;
      apb(1'h1, `OFS_IRQ_MASK, 32'h3);
      apb(1'h1, `OFS_IRQ_STATUS, 32'h3);
      uartIrqPending <= 1'h0;
      modemDetectIrq <= 1'h0;
      settle();
      check("irqClr", irq, 0);
      uartIrqPending <= 1'h1;
      settle();
      check("irqSet", irq, 1);
      apb(1'h0, `OFS_IRQ_STATUS, 0);
      check("sts", rdData, 1);
      apb(1'h1, `OFS_IRQ_MASK, 32'h2);
      settle();
      check("irqMsk", irq, 0);
      modemDetectIrq <= 1'h1;
      settle();
      check("irqMdm", irq, 1);
      apb(1'h1, `OFS_IRQ_STATUS, 32'h3);
      apb(1'h0, `OFS_IRQ_STATUS, 0);
      check("stsW1c", rdData, 0);
      check("irqW1c", irq, 0);
      apb(1'h0, 12'h010, 0);
      check("badErr", rdErr, 1);
      check("badDat", rdData, 0);
      apb(1'h1, `OFS_PIN_STATE, 32'h3f);
      check("roErr", rdErr, 0);
   endtask

   // hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         failCount++;
         reportAndStop();
      end
   end

   // main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      resetCase();
      irqPinCase();
      routeCase();
      pinsCase();
      statusCase();
      reportAndStop();
   end
endmodule // uart_modem_pin_steering_tb

bind uart_modem_pin_steering pin_steer_props #(.SPK_W(SPK_W)) pin_steer_props_inst (
   .clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .singlePortSelect,
   .hostReadStrobe_n, .uartIrqPending, .modemDetectIrq, .uartIrqOut, .uartIrqOutOe, .rxdPinIn,
   .rxdPinOut, .rxdPinOe, .modemRxData, .uartSerialIn, .uartSerialOut, .txdPinOut,
   .offHookDriverOut, .offHookDriverOe, .rxAudio, .speakerOut);

`default_nettype wire
